// [rtl/lcdm_pkg.sv]
// Package: register map, field positions, reset values and state carriers of the LCD memory block
package lcdm_pkg;
    localparam logic [11:0] ASTAT_OFS  = 12'h000;
    localparam logic [11:0] FC0_OFS    = 12'h004;
    localparam logic [11:0] FC1_OFS    = 12'h008;
    localparam logic [11:0] FC2_OFS    = 12'h00c;
    localparam logic [11:0] CTRL_OFS   = 12'h010;
    localparam logic [11:0] PHASE_OFS  = 12'h014;
    localparam logic [6:0]  FST_REGION = 7'h02;
    localparam logic [6:0]  SEC_REGION = 7'h03;

    localparam int NUM_FC    = 3;
    localparam int MEM_WORDS = 8;

    localparam int SRC_LSB      = 0;
    localparam int FST_DIS_BIT  = 2;
    localparam int SEC_EN_BIT   = 3;
    localparam int FST_CLR_BIT  = 4;
    localparam int FST_LOCK_BIT = 5;
    localparam int SEC_CLR_BIT  = 6;
    localparam int SEC_LOCK_BIT = 7;
    localparam int OVF_LSB      = 8;
    localparam int FST_ACT_BIT  = 12;
    localparam int SEC_ACT_BIT  = 13;
    localparam int BLANK_BIT    = 14;

    localparam int BMODE_LSB  = 0;
    localparam int BSEL_LSB   = 4;
    localparam int ALT_LSB    = 8;
    localparam int PANEL_BIT  = 15;
    localparam int WALLOW_BIT = 4;

    localparam logic [1:0]  SRC_FIRST     = 2'h0;
    localparam logic [1:0]  SRC_SECOND    = 2'h1;
    localparam logic [1:0]  SRC_ALT_ONCE  = 2'h2;
    localparam logic [1:0]  SRC_ALT_CONT  = 2'h3;
    localparam logic [2:0]  BLANK_SEL_FC2 = 3'h6;
    localparam logic [15:0] LIMIT_RST     = 16'h0000;
    localparam logic [15:0] CNT_STEP      = 16'h0001;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lcdm_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } lcdm_apb_rsp_s;

    typedef struct packed {
        lcdm_apb_rsp_s                     rsp;
        logic                              sec_lock;
        logic                              sec_clear;
        logic                              fst_lock;
        logic                              fst_clear;
        logic                              sec_en;
        logic                              fst_dis;
        logic [1:0]                        src_sel;
        logic                              panel_en;
        logic [1:0]                        blank_mode;
        logic [2:0]                        blank_sel;
        logic [2:0]                        alt_sel;
        logic                              write_allow;
        logic [NUM_FC-1:0][15:0]           limit;
        logic [NUM_FC-1:0][15:0]           cnt;
        logic [NUM_FC-1:0]                 ovf;
        logic [NUM_FC-1:0]                 ovf_pulse;
        logic                              blank_stat;
        logic                              show_second;
        logic                              alt_done;
        logic                              fst_act;
        logic                              sec_act;
        logic [MEM_WORDS-1:0][15:0]        mem_fst;
        logic [MEM_WORDS-1:0][15:0]        mem_sec;
        logic [MEM_WORDS-1:0][15:0]        pixels;
    } lcdm_state_s;
endpackage

// [rtl/lcdm_top.sv]
// LCD dual pixel memory control, display source selection and frame counters behind APB
module lcdm_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire lcdm_pkg::lcdm_apb_req_s apb_req,
    output lcdm_pkg::lcdm_apb_rsp_s     apb_rsp,
    input  wire logic                   frame_tick,
    output logic                        show_second,
    output logic                        first_active,
    output logic                        second_active,
    output logic                        blank_active,
    output logic [2:0]                  overflow_pulse,
    output logic [127:0]                display_pixels
);
    import lcdm_pkg::*;

    lcdm_state_s       q;
    lcdm_state_s       d;
    logic [NUM_FC-1:0] evt;
    logic              alt_evt;
    logic              setup;
    logic              wr;
    logic              hit;
    logic [31:0]       rdat;
    logic [2:0]        widx;
    logic [6:0]        region;
    logic              fst_ok;
    logic              blank_set;

    assign setup  = apb_req.psel & ~apb_req.penable;
    // Access is one cycle: pready was raised in the setup cycle
    assign wr     = apb_req.psel & apb_req.penable & apb_req.pwrite & q.rsp.pready
                    & ~q.rsp.pslverr;
    assign widx   = apb_req.paddr[4:2];
    assign region = apb_req.paddr[11:5];
    assign fst_ok = q.sec_en ? ~q.fst_lock : q.write_allow;

    always_comb begin
        hit  = 1'b1;
        rdat = 32'h0000_0000;
        if (region == FST_REGION) begin
            rdat[15:0] = q.mem_fst[widx];
        end else if (region == SEC_REGION) begin
            rdat[15:0] = q.mem_sec[widx];
        end else begin
            unique case (apb_req.paddr)
                ASTAT_OFS: begin
                    rdat[SRC_LSB +: 2]     = q.src_sel;
                    rdat[FST_DIS_BIT]      = q.fst_dis;
                    rdat[SEC_EN_BIT]       = q.sec_en;
                    rdat[FST_CLR_BIT]      = q.fst_clear;
                    rdat[FST_LOCK_BIT]     = q.fst_lock;
                    rdat[SEC_CLR_BIT]      = q.sec_clear;
                    rdat[SEC_LOCK_BIT]     = q.sec_lock;
                    rdat[OVF_LSB +: 3]     = q.ovf;
                    rdat[FST_ACT_BIT]      = q.fst_act;
                    rdat[SEC_ACT_BIT]      = q.sec_act;
                    rdat[BLANK_BIT]        = q.blank_stat;
                end
                FC0_OFS:   rdat[15:0] = q.limit[0];
                FC1_OFS:   rdat[15:0] = q.limit[1];
                FC2_OFS:   rdat[15:0] = q.limit[2];
                CTRL_OFS: begin
                    rdat[BMODE_LSB +: 2] = q.blank_mode;
                    rdat[BSEL_LSB +: 3]  = q.blank_sel;
                    rdat[ALT_LSB +: 3]   = q.alt_sel;
                    rdat[PANEL_BIT]      = q.panel_en;
                end
                PHASE_OFS: rdat[WALLOW_BIT] = q.write_allow;
                default:   hit = 1'b0;
            endcase
        end
    end

    always_comb begin
        d = q;
        for (int i = 0; i < NUM_FC; i++) begin
            evt[i] = q.panel_en & frame_tick
                     & (16'(q.cnt[i] + CNT_STEP) == q.limit[i]);
        end
        alt_evt   = (q.alt_sel < 3'h3) ? evt[q.alt_sel[1:0]] : 1'b0;
        blank_set = evt[2] & (q.blank_mode != 2'h0) & (q.blank_sel == BLANK_SEL_FC2);

        d.rsp.pready  = 1'b0;
        d.rsp.pslverr = 1'b0;
        if (setup) begin
            d.rsp.pready  = 1'b1;
            d.rsp.pslverr = ~hit;
            d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdat;
        end

        for (int i = 0; i < NUM_FC; i++) begin
            if (!q.panel_en || evt[i]) begin
                d.cnt[i] = 16'h0000;
            end else if (frame_tick) begin
                d.cnt[i] = 16'(q.cnt[i] + CNT_STEP);
            end
        end
        d.ovf_pulse = evt;

        if (wr) begin
            if (region == FST_REGION) begin
                // Locked writes still finish normally; data is dropped
                if (fst_ok) begin
                    d.mem_fst[widx] = apb_req.pwdata[15:0];
                end
            end else if (region == SEC_REGION) begin
                if (!q.sec_lock) begin
                    d.mem_sec[widx] = apb_req.pwdata[15:0];
                end
            end else begin
                unique case (apb_req.paddr)
                    ASTAT_OFS: begin
                        d.src_sel   = apb_req.pwdata[SRC_LSB +: 2];
                        d.fst_dis   = apb_req.pwdata[FST_DIS_BIT];
                        d.sec_en    = apb_req.pwdata[SEC_EN_BIT];
                        d.fst_clear = apb_req.pwdata[FST_CLR_BIT];
                        d.fst_lock  = apb_req.pwdata[FST_LOCK_BIT];
                        d.sec_clear = apb_req.pwdata[SEC_CLR_BIT];
                        d.sec_lock  = apb_req.pwdata[SEC_LOCK_BIT];
                        // Writing zero clears a flag; a same-cycle overflow still wins
                        d.ovf        = q.ovf & apb_req.pwdata[OVF_LSB +: 3];
                        d.blank_stat = q.blank_stat & apb_req.pwdata[BLANK_BIT];
                    end
                    FC0_OFS:   d.limit[0] = apb_req.pwdata[15:0];
                    FC1_OFS:   d.limit[1] = apb_req.pwdata[15:0];
                    FC2_OFS:   d.limit[2] = apb_req.pwdata[15:0];
                    CTRL_OFS: begin
                        d.blank_mode = apb_req.pwdata[BMODE_LSB +: 2];
                        d.blank_sel  = apb_req.pwdata[BSEL_LSB +: 3];
                        d.alt_sel    = apb_req.pwdata[ALT_LSB +: 3];
                        d.panel_en   = apb_req.pwdata[PANEL_BIT];
                    end
                    PHASE_OFS: d.write_allow = apb_req.pwdata[WALLOW_BIT];
                    default: begin
                    end
                endcase
            end
        end

        d.ovf = d.ovf | evt;
        d.blank_stat = d.blank_stat | blank_set;
        if (q.blank_mode == 2'h0 || !q.panel_en) begin
            d.blank_stat = 1'b0;
        end

        // Clear is held while the bit stays set, so the memory reads zero throughout
        if (d.fst_clear) begin
            d.mem_fst = '0;
        end
        if (d.sec_clear) begin
            d.mem_sec = '0;
        end

        unique case (q.src_sel)
            SRC_FIRST: begin
                d.show_second = 1'b0;
                d.alt_done    = 1'b0;
            end
            SRC_SECOND: begin
                d.show_second = 1'b1;
                d.alt_done    = 1'b0;
            end
            SRC_ALT_ONCE: begin
                // One round trip to secondary and back, then rest on primary
                if (alt_evt && !q.alt_done) begin
                    d.show_second = ~q.show_second;
                    d.alt_done    = q.show_second;
                end
            end
            SRC_ALT_CONT: begin
                if (alt_evt) begin
                    d.show_second = ~q.show_second;
                end
            end
        endcase

        d.sec_act = d.show_second & q.sec_en;
        d.fst_act = ~d.show_second & ~q.fst_dis;
        if (d.blank_stat) begin
            d.pixels = '0;
        end else begin
            d.pixels = d.show_second ? d.mem_sec : d.mem_fst;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q       <= '0;
            q.limit <= {NUM_FC{LIMIT_RST}};
        end else begin
            q <= d;
        end
    end

    assign apb_rsp        = q.rsp;
    assign show_second    = q.show_second;
    assign first_active   = q.fst_act;
    assign second_active  = q.sec_act;
    assign blank_active   = q.blank_stat;
    assign overflow_pulse = q.ovf_pulse;
    assign display_pixels = q.pixels;

    sequence s_apb_setup;
        apb_req.psel && !apb_req.penable;
    endsequence

    sequence s_one_access;
        apb_rsp.pready ##1 !apb_rsp.pready;
    endsequence

    a_sec_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
        wr && region == SEC_REGION && q.sec_lock && !d.sec_clear |=> q.mem_sec == $past(q.mem_sec))
        else $error("locked secondary memory changed");

    a_sec_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        q.sec_clear |-> q.mem_sec == '0)
        else $error("secondary memory not zero while clear set");

    a_fst_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
        wr && region == FST_REGION && q.sec_en && q.fst_lock && !d.fst_clear
        |=> q.mem_fst == $past(q.mem_fst))
        else $error("locked primary memory changed");

    a_fst_wa_path: assert property (@(posedge pclk) disable iff (!presetn)
        wr && region == FST_REGION && !q.sec_en && q.write_allow && !d.fst_clear
        |=> q.mem_fst[$past(widx)] == $past(apb_req.pwdata[15:0]))
        else $error("write-allowed primary write lost");

    // The output trails the field by one cycle, so the select must stand three cycles
    a_src_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        q.src_sel == SRC_SECOND [*3] |-> q.show_second && $stable(q.show_second))
        else $error("fixed secondary source not shown");

    a_alt_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        q.src_sel == SRC_ALT_CONT && alt_evt |=> q.show_second != $past(q.show_second))
        else $error("continuous alternation missed a toggle");

    a_alt_once_stop: assert property (@(posedge pclk) disable iff (!presetn)
        q.src_sel == SRC_ALT_ONCE && q.alt_done && !q.show_second |=> !q.show_second)
        else $error("single alternation did not stop on primary");

    a_ovf_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        evt[0] |=> q.ovf[0] && q.ovf_pulse[0] && q.cnt[0] == 16'h0000)
        else $error("counter 0 overflow not reported");

    a_blank_hw_clr: assert property (@(posedge pclk) disable iff (!presetn)
        !q.panel_en || q.blank_mode == 2'h0 |=> !q.blank_stat)
        else $error("blank status not cleared by hardware");

    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        s_apb_setup |=> s_one_access)
        else $error("apb answer not exactly one access cycle");

    a_no_err_mem: assert property (@(posedge pclk) disable iff (!presetn)
        (s_apb_setup and (region == FST_REGION || region == SEC_REGION)) |=> !apb_rsp.pslverr)
        else $error("memory access flagged as error");

    a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error response without ready");

    a_sec_open_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && region == SEC_REGION && !q.sec_lock && !d.sec_clear
        |=> q.mem_sec[$past(widx)] == $past(apb_req.pwdata[15:0]))
        else $error("unlocked secondary write lost");

    a_fst_wa_block: assert property (@(posedge pclk) disable iff (!presetn)
        wr && region == FST_REGION && !q.sec_en && !q.write_allow
        |=> q.mem_fst == $past(q.mem_fst))
        else $error("primary write taken without write allow");

    a_fst_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        q.fst_clear |-> q.mem_fst == '0)
        else $error("primary memory not zero while clear set");

    a_sec_act_out: assert property (@(posedge pclk) disable iff (!presetn)
        !q.sec_en |=> !second_active)
        else $error("secondary shown active while disabled");

    a_fst_act_out: assert property (@(posedge pclk) disable iff (!presetn)
        q.fst_dis |=> !first_active)
        else $error("primary shown active while disabled");

    a_src_first: assert property (@(posedge pclk) disable iff (!presetn)
        q.src_sel == SRC_FIRST |=> !show_second)
        else $error("fixed primary source not shown");

    a_cont_hold: assert property (@(posedge pclk) disable iff (!presetn)
        q.src_sel == SRC_ALT_CONT && !alt_evt |=> $stable(q.show_second))
        else $error("continuous alternation toggled without event");

    a_once_hold: assert property (@(posedge pclk) disable iff (!presetn)
        q.src_sel == SRC_ALT_ONCE && !alt_evt |=> $stable(q.show_second))
        else $error("single alternation toggled without event");

    // Counting only runs with the panel on; an idle panel restarts every count
    a_cnt_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !q.panel_en |=> q.cnt == '0)
        else $error("frame counters not held at zero while panel off");

    a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
        q.panel_en && frame_tick && !evt[0] |=> q.cnt[0] == 16'($past(q.cnt[0]) + CNT_STEP))
        else $error("counter 0 did not advance on frame tick");

    a_limit_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && apb_req.paddr == FC1_OFS |=> q.limit[1] == $past(apb_req.pwdata[15:0]))
        else $error("counter 1 limit write lost");

    sequence s_fc0_read;
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == FC0_OFS;
    endsequence

    a_limit_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_fc0_read |=> apb_rsp.prdata == {16'h0000, $past(q.limit[0])})
        else $error("counter 0 limit read back wrong");

    a_pulse_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (overflow_pulse & ~q.ovf) == 3'h0)
        else $error("overflow pulse without sticky flag");

    a_blank_set: assert property (@(posedge pclk) disable iff (!presetn)
        blank_set |=> blank_active)
        else $error("blank status not set by counter 2 overflow");

    a_blank_dark: assert property (@(posedge pclk) disable iff (!presetn)
        blank_active |-> display_pixels == '0)
        else $error("pixels shown while blank status set");
endmodule // lcdm_top

// [sim/lcdm_top_tb.sv]
// Self-checking bench for the LCD dual memory, source select and frame counter block
module lcdm_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lcdm_pkg::*;

    localparam logic [31:0] SLK = 32'h1 << SEC_LOCK_BIT;
    localparam logic [31:0] SCL = 32'h1 << SEC_CLR_BIT;
    localparam logic [31:0] FLK = 32'h1 << FST_LOCK_BIT;
    localparam logic [31:0] FCL = 32'h1 << FST_CLR_BIT;
    localparam logic [31:0] SEN = 32'h1 << SEC_EN_BIT;
    localparam logic [31:0] FDS = 32'h1 << FST_DIS_BIT;
    localparam logic [31:0] PAN = 32'h1 << PANEL_BIT;
    localparam logic [31:0] BLK = PAN | (32'h1 << BMODE_LSB) | (32'(BLANK_SEL_FC2) << BSEL_LSB);

    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    lcdm_apb_req_s apb_req = '0;
    lcdm_apb_rsp_s apb_rsp;
    logic          frame_tick = 1'b0;
    logic          show_second;
    logic          first_active;
    logic          second_active;
    logic          blank_active;
    logic [2:0]    overflow_pulse;
    logic [127:0]  display_pixels;
    int            err_total = 0;
    int            samples_checked = 0;
    int            pulses [3] = '{0, 0, 0};
    logic [31:0]   rdat;
    logic          rerr;
    logic [15:0]   fst_m [8];
    logic [15:0]   sec_m [8];
    logic [2:0]    alt_exp [2][3] = '{'{3'h1, 3'h0, 3'h1}, '{3'h1, 3'h0, 3'h0}};

    always #2.5 pclk = ~pclk;

    lcdm_top u_lcdm_top (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .frame_tick(frame_tick), .show_second(show_second), .first_active(first_active),
        .second_active(second_active), .blank_active(blank_active),
        .overflow_pulse(overflow_pulse), .display_pixels(display_pixels)
    );

    always @(posedge pclk) begin
        for (int i = 0; i < 3; i++) if (overflow_pulse[i] === 1'b1) pulses[i]++;
    end

    task automatic chk(input string what, input logic [135:0] seen, input logic [135:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Holds the request until pready is seen high at a rising edge, as APB asks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req.psel   <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr  <= a;
        apb_req.pwdata <= d;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        if (apb_rsp.pready !== 1'b1) begin
            err_total++;
            results();
        end
        rdat = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rdat, exp);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            frame_tick <= 1'b1;
            @(posedge pclk);
            frame_tick <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask

    function automatic logic [11:0] maddr(input logic sec, input int i);
        return {sec ? SEC_REGION : FST_REGION, 5'h00} + 12'(4 * i);
    endfunction

    function automatic logic [127:0] img(input logic sec);
        logic [127:0] v;
        for (int i = 0; i < 8; i++) v[16*i +: 16] = sec ? sec_m[i] : fst_m[i];
        return v;
    endfunction

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Limits are written only while the panel is off
        for (int i = 0; i < 3; i++) begin
            rdc("limit reset", FC0_OFS + 12'(4 * i), 32'h0);
            wr(FC0_OFS + 12'(4 * i), {16'hffff, 16'(3 + i)});
            rdc("limit", FC0_OFS + 12'(4 * i), 32'(3 + i));
        end
        wr(12'h800, 32'h1);
        chk("unmapped err", rerr, 1'b1);
        // Secondary is still off, so primary writes follow the write-allow flag
        wr(PHASE_OFS, 32'h1 << WALLOW_BIT);
        for (int i = 0; i < 8; i++) begin
            fst_m[i] = 16'h1100 + 16'(i);
            sec_m[i] = 16'h2200 + 16'(i);
            wr(maddr(1'b0, i), 32'(fst_m[i]));
        end
        rdc("memory read", maddr(1'b0, 0), 32'(fst_m[0]));
        repeat (2) @(posedge pclk);
        chk("primary image", {show_second, first_active, display_pixels}, {2'b01, img(1'b0)});
        wr(ASTAT_OFS, SEN | 32'(SRC_SECOND));
        for (int i = 0; i < 8; i++) wr(maddr(1'b1, i), 32'(sec_m[i]));
        repeat (2) @(posedge pclk);
        chk("second image", {show_second, second_active, display_pixels}, {2'b11, img(1'b1)});
        wr(ASTAT_OFS, SEN | SLK | 32'(SRC_SECOND));
        wr(maddr(1'b1, 0), 32'hbeef);
        chk("locked write err", rerr, 1'b0);
        repeat (2) @(posedge pclk);
        chk("second locked", display_pixels, img(1'b1));
        wr(ASTAT_OFS, SEN | FLK);
        wr(maddr(1'b0, 0), 32'hbeef);
        repeat (2) @(posedge pclk);
        chk("first locked", display_pixels, img(1'b0));
        wr(ASTAT_OFS, FLK);
        wr(PHASE_OFS, 32'h1 << WALLOW_BIT);
        wr(maddr(1'b0, 0), 32'h0bad);
        fst_m[0] = 16'h0bad;
        wr(PHASE_OFS, 32'h0);
        wr(maddr(1'b0, 1), 32'hbeef);
        repeat (2) @(posedge pclk);
        chk("write allow", display_pixels, img(1'b0));
        wr(ASTAT_OFS, 32'(SRC_SECOND));
        repeat (2) @(posedge pclk);
        chk("second disabled", {show_second, second_active}, 2'b10);
        wr(ASTAT_OFS, FDS);
        repeat (2) @(posedge pclk);
        chk("first disabled", {first_active, second_active}, 2'b00);
        pulses = '{0, 0, 0};
        wr(CTRL_OFS, PAN);
        ticks(12);
        chk("overflow count", {pulses[0], pulses[1], pulses[2]}, {32'd4, 32'd3, 32'd2});
        rdc("overflow flags", ASTAT_OFS, 32'h0704);
        wr(ASTAT_OFS, FDS);
        rdc("flags cleared", ASTAT_OFS, 32'h0004);
        // Counter 0 paces alternation: continuous first, then a single round trip
        for (int m = 0; m < 2; m++) begin
            wr(CTRL_OFS, 32'h0);
            wr(ASTAT_OFS, SEN);
            wr(ASTAT_OFS, SEN | 32'(m == 0 ? SRC_ALT_CONT : SRC_ALT_ONCE));
            wr(CTRL_OFS, PAN);
            for (int k = 0; k < 3; k++) begin
                ticks(3);
                chk("alternation", show_second, alt_exp[m][k][0]);
            end
        end
        wr(ASTAT_OFS, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(CTRL_OFS, 32'h0);
            wr(CTRL_OFS, BLK);
            ticks(5);
            chk("blank set", {blank_active, display_pixels}, {1'b1, 128'h0});
            if (k == 0) wr(CTRL_OFS, BLK & ~(32'h3 << BMODE_LSB));
            if (k == 1) wr(CTRL_OFS, 32'h0);
            if (k == 2) wr(ASTAT_OFS, 32'h0);
            repeat (2) @(posedge pclk);
            chk("blank cleared", blank_active, 1'b0);
        end
        wr(CTRL_OFS, 32'h0);
        wr(ASTAT_OFS, FCL);
        wr(ASTAT_OFS, 32'h0);
        repeat (2) @(posedge pclk);
        chk("first cleared", display_pixels, 128'h0);
        wr(ASTAT_OFS, SEN | SCL | 32'(SRC_SECOND));
        wr(ASTAT_OFS, SEN | 32'(SRC_SECOND));
        repeat (2) @(posedge pclk);
        chk("second cleared", display_pixels, 128'h0);
        results();
    end
endmodule // lcdm_top_tb
